// *** hdl/fp_unit_params.svh ***
`ifndef FP_UNIT_PARAMS_SVH
`define FP_UNIT_PARAMS_SVH
// ----------------------------------------
// register offsets (byte addresses; tag word as a word index)
// ----------------------------------------
`define OFS_AUX 8'h40
`define OFS_CMP 8'h44
`define OFS_CLASS 8'h48
`define OFS_CONV 8'h50
`define OFS_MOVE 8'h60
`define OFS_TAG_WORD 2'h3
// ----------------------------------------
// aux status fields and reset
// ----------------------------------------
`define AUX_UO_POS 8
`define AUX_GT_POS 9
`define AUX_LT_POS 10
`define AUX_EQ_POS 11
`define AUX_RC_LSB 12
`define AUX_TM_LSB 16
`define AUX_CSC_POS 24
`define AUX_RC_NEAREST 2'h0
`define AUX_RESET 32'h00000000
// ----------------------------------------
// exponent rebias to extended form
// ----------------------------------------
`define ADJ_SINGLE 15'h3F80
`define ADJ_DOUBLE 15'h3C00
`define EXT_BIAS_P31 15'h401E
`endif

// *** hdl/fp_unit_pkg.sv ***
`default_nettype none
package fp_unit_pkg;
	typedef enum logic [1:0] {
		FMT_SINGLE = 2'b00,
		FMT_DOUBLE = 2'b01,
		FMT_EXT = 2'b10
	} fmt_type;
	typedef enum logic [2:0] {
		CLS_ZERO = 3'b000,
		CLS_DENORM = 3'b001,
		CLS_NORMAL = 3'b010,
		CLS_INF = 3'b011,
		CLS_NAN = 3'b100
	} class_type;
	typedef enum logic [1:0] {
		CMP_EQ = 2'b00,
		CMP_LT = 2'b01,
		CMP_GT = 2'b10,
		CMP_UO = 2'b11
	} cmp_type;
	// operand in common extended form
	typedef struct packed {
		logic sign;
		logic [14:0] exp;
		logic [63:0] sig;
		class_type cls;
	} ext_type;
endpackage
`default_nettype wire

// *** hdl/float_operand_format_unit.sv ***
// Functional notes
// - single: sign bit 31, exponent 30..23, fraction 22..0.
// - single bias 127; exponent 1..254 is normal with hidden one.
// - single: denormal, zero, infinity and NaN by exponent and fraction.
// - double: sign bit 63, exponent 62..52, fraction 51..0.
// - double bias 1023; exponent 1..2046 is normal with hidden one.
// - double: denormal, zero, infinity and NaN by exponent and fraction.
// - operands sit on four-byte boundaries; only word accesses exist.
// - extended operand is a 96-bit container of three words.
// - extended bits 95..80 ignored on load, zero on store.
// - extended: sign 79, exponent 78..64 bias 16383, j bit 63.
// - extended classes ignore the explicit bit; exponent 32767 is infinity or NaN.
// - four operand registers, each holding any of three formats.
// - registers hold float encodings only; integers converted on entry.
// - formatless destination rounds to the precision of the opcode; here a move with format code 3 changes no register.
// - aux status holds rounding, trap mask, context bits; whole-word access.
// - aux status has an unordered condition bit apart from host flags.
// - compare gives exactly one of equal, less, greater, unordered.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fp_unit_params.svh"
module float_operand_format_unit
	import fp_unit_pkg::*;
#(
	parameter int RC_LSB = `AUX_RC_LSB,
	parameter int TM_LSB = `AUX_TM_LSB,
	parameter int CSC_POS = `AUX_CSC_POS,
	parameter logic [1:0] RC_RESET = `AUX_RC_NEAREST
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o
);
	logic [95:0] op_q [4];
	fmt_type fmt_q [4];
	logic [31:0] stat_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_d;
	logic [1:0] rmode;
	// -----------------------------
	// format helpers
	// -----------------------------
	function automatic ext_type unpack(input fmt_type f, input logic [95:0] c);
		ext_type x;
		logic [14:0] re;
		logic [14:0] adj;
		logic [62:0] fr;
		logic j;
		logic emax;
		x = '0;
		case (f)
			FMT_SINGLE: begin
				x.sign = c[31];
				re = {7'h00, c[30:23]};
				fr = {c[22:0], 40'h0};
				emax = &c[30:23];
				j = |c[30:23];
				adj = `ADJ_SINGLE;
			end
			FMT_DOUBLE: begin
				x.sign = c[63];
				re = {4'h0, c[62:52]};
				fr = {c[51:0], 11'h0};
				emax = &c[62:52];
				j = |c[62:52];
				adj = `ADJ_DOUBLE;
			end
			default: begin
				x.sign = c[79];
				re = c[78:64];
				fr = c[62:0];
				emax = &c[78:64];
				j = c[63];
				adj = 15'h0000;
			end
		endcase
		x.sig = {j, fr};
		if (emax) begin
			x.exp = 15'h7FFF;
			x.cls = (fr == 63'h0) ? CLS_INF : CLS_NAN;
		end else if (re == 15'h0000) begin
			x.exp = adj + 15'h0001; // denormal scale is bias minus one
			x.cls = (fr == 63'h0) ? CLS_ZERO : CLS_DENORM;
		end else begin
			x.exp = re + adj;
			x.cls = CLS_NORMAL;
		end
		return x;
	endfunction
	// rounding increment for each rounding mode
	function automatic logic rnd_inc(input logic [1:0] rm, input logic sg,
		input logic lsb, input logic r, input logic s);
		case (rm)
			2'h0: rnd_inc = r & (s | lsb);
			2'h1: rnd_inc = ~sg & (r | s);
			2'h2: rnd_inc = sg & (r | s);
			default: rnd_inc = 1'b0;
		endcase
	endfunction
	// re-encode into a container, narrowing with rounding
	function automatic logic [95:0] pack(input fmt_type f, input ext_type x,
		input logic [1:0] rm);
		logic [95:0] c;
		logic signed [17:0] te;
		logic inc;
		c = '0;
		case (f)
			FMT_SINGLE: begin
				te = $signed({3'b000, x.exp}) - $signed({3'b000, `ADJ_SINGLE});
				inc = rnd_inc(rm, x.sign, x.sig[40], x.sig[39], |x.sig[38:0]);
				if (x.cls == CLS_NAN)
					c[31:0] = {x.sign, 8'hFF, x.sig[62:41], 1'b1};
				else if (x.cls == CLS_INF || te >= 18'sd255)
					c[31:0] = {x.sign, 8'hFF, 23'h0};
				else if (x.cls == CLS_ZERO || te <= 18'sd0)
					c[31] = x.sign; // tiny results flush to zero
				else
					c[31:0] = {x.sign, te[7:0], x.sig[62:40]} + {31'h0, inc};
			end
			FMT_DOUBLE: begin
				te = $signed({3'b000, x.exp}) - $signed({3'b000, `ADJ_DOUBLE});
				inc = rnd_inc(rm, x.sign, x.sig[11], x.sig[10], |x.sig[9:0]);
				if (x.cls == CLS_NAN)
					c[63:0] = {x.sign, 11'h7FF, x.sig[62:12], 1'b1};
				else if (x.cls == CLS_INF || te >= 18'sd2047)
					c[63:0] = {x.sign, 11'h7FF, 52'h0};
				else if (x.cls == CLS_ZERO || te <= 18'sd0)
					c[63] = x.sign;
				else
					c[63:0] = {x.sign, te[10:0], x.sig[62:11]} + {63'h0, inc};
			end
			default: begin
				c[79] = x.sign;
				if (x.cls != CLS_ZERO)
					c[78:0] = {x.exp, x.sig}; // zero keeps a zero exponent
			end
		endcase
		return c;
	endfunction
	// ordering of two operands
	function automatic cmp_type compare(input ext_type a, input ext_type b);
		logic [78:0] ka;
		logic [78:0] kb;
		ka = (a.cls == CLS_ZERO) ? 79'h0 : {a.exp, a.sig};
		kb = (b.cls == CLS_ZERO) ? 79'h0 : {b.exp, b.sig};
		if (a.cls == CLS_NAN || b.cls == CLS_NAN)
			compare = CMP_UO;
		else if (ka == 79'h0 && kb == 79'h0)
			compare = CMP_EQ;
		else if (a.sign != b.sign)
			compare = a.sign ? CMP_LT : CMP_GT;
		else if (ka == kb)
			compare = CMP_EQ;
		else if ((ka < kb) ^ a.sign)
			compare = CMP_LT;
		else
			compare = CMP_GT;
	endfunction
	// -----------------------------
	// decoded strobes
	// -----------------------------
	logic op_area;
	logic [1:0] sel_reg;
	logic [1:0] sel_word;
	logic wr_cmp;
	logic wr_move;
	logic wr_conv;
	ext_type src_a;
	ext_type src_b;
	cmp_type cmp_res;
	assign op_area = (addr_i[7:6] == 2'b00);
	assign sel_reg = addr_i[5:4];
	assign sel_word = addr_i[3:2];
	assign wr_cmp = wr_i && addr_i == `OFS_CMP;
	assign wr_move = wr_i && addr_i == `OFS_MOVE;
	assign wr_conv = wr_i && addr_i[7:4] == 4'(`OFS_CONV >> 4);
	assign rmode = stat_q[RC_LSB +: 2];
	assign src_a = unpack(fmt_q[wdata_i[1:0]], op_q[wdata_i[1:0]]);
	assign src_b = unpack(fmt_q[wdata_i[3:2]], op_q[wdata_i[3:2]]);
	assign cmp_res = compare(src_a, src_b);
	// -----------------------------
	// integer to extended conversion
	// -----------------------------
	logic [31:0] int_mag;
	logic [4:0] int_lz;
	logic [95:0] int_ext;
	always_comb begin
		int_mag = wdata_i[31] ? (~wdata_i + 32'h1) : wdata_i;
		int_lz = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (int_mag[i])
				int_lz = 5'(31 - i);
		end
		int_ext = '0;
		if (int_mag != 32'h0)
			int_ext[79:0] = {wdata_i[31], `EXT_BIAS_P31 - {10'h000, int_lz},
				int_mag << int_lz, 32'h0};
	end
	// -----------------------------
	// operand registers
	// -----------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			for (int r = 0; r < 4; r++) begin
				op_q[r] <= '0;
				fmt_q[r] <= FMT_SINGLE;
			end
		end else if (wr_i && op_area) begin
			if (sel_word == `OFS_TAG_WORD) begin
				if (wdata_i[1:0] != 2'b11)
					fmt_q[sel_reg] <= fmt_type'(wdata_i[1:0]);
			end else if (sel_word == 2'h2)
				op_q[sel_reg][95:64] <= {16'h0000, wdata_i[15:0]};
			else
				op_q[sel_reg][32 * sel_word +: 32] <= wdata_i;
		end else if (wr_conv) begin
			op_q[addr_i[3:2]] <= int_ext;
			fmt_q[addr_i[3:2]] <= FMT_EXT;
		end else if (wr_move && wdata_i[5:4] != 2'b11) begin
			op_q[wdata_i[3:2]] <= pack(fmt_type'(wdata_i[5:4]), src_a, rmode);
			fmt_q[wdata_i[3:2]] <= fmt_type'(wdata_i[5:4]);
		end
	end
	// -----------------------------
	// aux status register
	// -----------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			stat_q <= `AUX_RESET;
			stat_q[RC_LSB +: 2] <= RC_RESET;
		end else if (wr_i && addr_i == `OFS_AUX)
			stat_q <= wdata_i;
		else if (wr_cmp) begin
			stat_q[`AUX_UO_POS] <= (cmp_res == CMP_UO);
			stat_q[`AUX_GT_POS] <= (cmp_res == CMP_GT);
			stat_q[`AUX_LT_POS] <= (cmp_res == CMP_LT);
			stat_q[`AUX_EQ_POS] <= (cmp_res == CMP_EQ);
		end
	end
	// -----------------------------
	// read path
	// -----------------------------
	class_type reg_cls [4];
	// class of every register for the class word
	for (genvar g = 0; g < 4; g++) begin : g_cls
		ext_type unp;
		assign unp = unpack(fmt_q[g], op_q[g]);
		assign reg_cls[g] = unp.cls;
	end
	always_comb begin
		rd_d = 32'h0;
		if (op_area) begin
			if (sel_word == `OFS_TAG_WORD)
				rd_d = {30'h0, fmt_q[sel_reg]};
			else
				rd_d = op_q[sel_reg][32 * sel_word +: 32];
		end else if (addr_i == `OFS_AUX)
			rd_d = stat_q;
		else if (addr_i == `OFS_CLASS) begin
			for (int r = 0; r < 4; r++)
				rd_d[3 * r +: 3] = reg_cls[r];
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (rst_i)
			rdata_q <= 32'h0;
		else
			rdata_q <= rd_i ? rd_d : 32'h0;
	end
	assign rdata_o = rdata_q;
	// -----------------------------
	// checks
	// -----------------------------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_one_outcome;
		$past(wr_cmp) |-> $onehot(stat_q[`AUX_EQ_POS:`AUX_UO_POS]);
	endproperty
	a_one_outcome: assert property (p_one_outcome) else $error("compare not one-hot");
	property p_nan_unordered;
		wr_cmp && (src_a.cls == CLS_NAN) |=> stat_q[`AUX_UO_POS];
	endproperty
	a_nan_unordered: assert property (p_nan_unordered) else $error("NaN not unordered");
	property p_top_zero;
		(op_q[0][95:80] == 16'h0) && (op_q[3][95:80] == 16'h0);
	endproperty
	a_top_zero: assert property (p_top_zero) else $error("unused bits set");
	property p_no_int_tag;
		fmt_q[1] != 2'b11 && fmt_q[2] != 2'b11;
	endproperty
	a_no_int_tag: assert property (p_no_int_tag) else $error("bad format tag");
	property p_conv_ext;
		wr_conv |=> fmt_q[$past(addr_i[3:2])] == FMT_EXT;
	endproperty
	a_conv_ext: assert property (p_conv_ext) else $error("conversion not extended");
	property p_move_fmt;
		wr_move && wdata_i[5:4] != 2'b11 |=> fmt_q[$past(wdata_i[3:2])] == $past(wdata_i[5:4]);
	endproperty
	a_move_fmt: assert property (p_move_fmt) else $error("move format wrong");
	property p_aux_read;
		rd_i && addr_i == `OFS_AUX |=> rdata_o == $past(stat_q);
	endproperty
	a_aux_read: assert property (p_aux_read) else $error("status read mismatch");
	property p_ctl_write;
		wr_i && addr_i == `OFS_AUX |=> stat_q[TM_LSB] == $past(wdata_i[TM_LSB])
			&& stat_q[CSC_POS] == $past(wdata_i[CSC_POS]);
	endproperty
	a_ctl_write: assert property (p_ctl_write) else $error("control bits not written");
	property p_rc_reset;
		$fell(rst_i) |-> stat_q[RC_LSB +: 2] == RC_RESET;
	endproperty
	a_rc_reset: assert property (p_rc_reset) else $error("bad rounding reset");
	property p_single_inf;
		fmt_q[0] == FMT_SINGLE && op_q[0][30:23] == 8'hFF && op_q[0][22:0] == 23'h0
			|-> reg_cls[0] == CLS_INF;
	endproperty
	a_single_inf: assert property (p_single_inf) else $error("single inf class");
	property p_idle_read;
		!rd_i |=> rdata_o == 32'h0;
	endproperty
	a_idle_read: assert property (p_idle_read) else $error("read data lingers");
endmodule
`default_nettype wire

// *** tb/host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	output logic [7:0] addr_o,
	output logic [31:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	// ------------------------------
	// idle bus at time zero
	// ------------------------------
	initial begin
		addr_o = 8'hFF;
		wdata_o = 32'hFFFFFFFF;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// ------------------------------
	// bus cycles
	// ------------------------------
	// one write cycle, word addresses only
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= {a[7:2], 2'b00};
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a; // released bus must not keep the old value
		wdata_o <= ~d;
	endtask
	// read strobe, data taken in the following cycle
	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= {a[7:2], 2'b00};
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		d = rdata_i; // data stand in the cycle after the strobe
	endtask
	// whole-word read, merge, write back
	task automatic rmw(input logic [7:0] a, input logic [31:0] clr,
		input logic [31:0] set);
		logic [31:0] d;
		bus_read(a, d);
		bus_write(a, (d & ~clr) | set);
	endtask
	// container goes as three words, then the format tag
	task automatic load_op(input logic [1:0] r, input logic [1:0] f, input logic [95:0] v);
		bus_write({2'b00, r, 4'h0}, v[31:0]);
		bus_write({2'b00, r, 4'h4}, v[63:32]);
		bus_write({2'b00, r, 4'h8}, v[95:64]);
		bus_write({2'b00, r, 4'hC}, {30'h0, f});
	endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import fp_unit_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	int n_fail = 0;
	int check_count = 0;
	logic [95:0] cv [18] = '{96'h0, 96'h80000001, 96'h00800000, 96'h7F7FFFFF, 96'hFF800000,
		96'h7F800001, 96'h80000000, 96'h0010000000000000, 96'h7FEFFFFFFFFFFFFF,
		96'hFFF0000000000000, 96'h7FF0000000000001, 96'h8000000000000000,
		96'hFFFF00000000000000000000, 96'h1, 96'h3FFF8000000000000000,
		96'hFFFF0000000000000000, 96'h8000000000000000, 96'h17FFFC000000000000000};
	class_type cc [18] = '{CLS_ZERO, CLS_DENORM, CLS_NORMAL, CLS_NORMAL, CLS_INF, CLS_NAN,
		CLS_DENORM, CLS_NORMAL, CLS_NORMAL, CLS_INF, CLS_NAN, CLS_ZERO,
		CLS_ZERO, CLS_DENORM, CLS_NORMAL, CLS_INF, CLS_ZERO, CLS_NAN};
	// ------------------------------
	// clock, design and host
	// ------------------------------
	always #25 core_clk_i = ~core_clk_i;
	float_operand_format_unit uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
	host_bus_model host (.clk_i(core_clk_i), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	// ------------------------------
	// compare helpers
	// ------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		host.bus_read(a, d);
		check(d, exp);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_reset();
		rd_chk(8'h40, 32'h0);
		rd_chk(8'h48, 32'h0);
		rd_chk(8'h2C, 32'h0);
		host.bus_write(8'h7C, 32'hFFFFFFFF);
		rd_chk(8'h7C, 32'h0);
		host.bus_write(8'h0C, 32'h3);
		rd_chk(8'h0C, 32'h0);
		$display("done reset");
	endtask
	// each format in its own register, every class
	task automatic t_classify();
		logic [31:0] d;
		logic [31:0] got;
		logic [31:0] want;
		int r;
		for (int i = 0; i < 18; i++) begin
			r = i / 6;
			host.load_op(r[1:0], r[1:0], cv[i]);
			host.bus_read(8'h48, d);
			got = {29'h0, d[3*r +: 3]};
			want = {29'h0, cc[i]};
			if (r == 0) check(got, want);
			else if (r == 1) check(got, want);
			else check(got, want);
		end
		rd_chk(8'h28, 32'h00007FFF);
		$display("done classify");
	endtask
	// 1.0, 2.0, double 1.0, NaN; each compare sets one bit
	task automatic t_compare();
		logic [5:0] ct [5] = '{6'h24, 6'h11, 6'h03, 6'h0C, 6'h38};
		host.load_op(2'd0, FMT_SINGLE, 96'h3F800000);
		host.load_op(2'd1, FMT_SINGLE, 96'h40000000);
		host.load_op(2'd2, FMT_DOUBLE, 96'h3FF0000000000000);
		host.load_op(2'd3, FMT_SINGLE, 96'h7FC00000);
		for (int i = 0; i < 5; i++) begin
			host.bus_write(8'h44, {28'h0, ct[i][3:0]});
			rd_chk(8'h40, 32'h100 << ct[i][5:4]);
		end
		$display("done compare");
	endtask
	task automatic t_status();
		host.rmw(8'h40, 32'h0, 32'h01011000);
		rd_chk(8'h40, 32'h01011800);
		host.bus_write(8'h40, 32'h0);
		rd_chk(8'h40, 32'h0);
		$display("done status");
	endtask
	task automatic t_convert();
		logic [31:0] iv [3] = '{32'h1, 32'h7FFFFFFF, 32'h80000000};
		logic [63:0] ev [3] = '{64'h3FFF80000000, 64'h401DFFFFFFFE, 64'hC01E80000000};
		for (int i = 0; i < 3; i++) begin
			host.bus_write(8'h54 + 8'(4 * i), iv[i]);
			rd_chk(8'h18 + 8'(16 * i), ev[i][63:32]);
			rd_chk(8'h14 + 8'(16 * i), ev[i][31:0]);
			rd_chk(8'h10 + 8'(16 * i), 32'h0);
			rd_chk(8'h1C + 8'(16 * i), 32'h2);
		end
		$display("done convert");
	endtask
	// a tie to single under every rounding mode, then an exact double
	task automatic t_move();
		host.load_op(2'd0, FMT_EXT, {32'h3FFF, 32'h80000080, 32'h0});
		for (int m = 0; m < 4; m++) begin
			host.rmw(8'h40, 32'h3000, 32'(m) << 12);
			host.bus_write(8'h60, 32'h04);
			rd_chk(8'h10, (m == 1) ? 32'h3F800001 : 32'h3F800000);
			rd_chk(8'h1C, 32'h0);
		end
		host.bus_write(8'h60, 32'h18);
		rd_chk(8'h24, 32'h3FF00000);
		rd_chk(8'h20, 32'h10000000);
		rd_chk(8'h2C, 32'h1);
		host.bus_write(8'h60, 32'h34);
		rd_chk(8'h10, 32'h3F800000);
		host.bus_write(8'h60, 32'h2C);
		rd_chk(8'h38, 32'h00003FFF);
		rd_chk(8'h34, 32'h80000080);
		rd_chk(8'h3C, 32'h2);
		$display("done move");
	endtask
	// ------------------------------
	// main sequence and watchdog
	// ------------------------------
	initial begin
		repeat (20) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_classify();
		t_compare();
		t_status();
		t_convert();
		t_move();
		final_report();
	end
	initial begin
		repeat (5000) @(posedge core_clk_i);
		n_fail++;
		final_report();
	end
endmodule
`default_nettype wire
